// ---- bench/peripheral_clock_source_select_tb_top.sv ----
// self-checking bench for the peripheral clock source selector
// assumes a wishbone answer (ack or err) and static source levels between switches
`timescale 1ns/1ns
`default_nettype none
module peripheral_clock_source_select_tb_top;
  import clksel_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic sup = 1'b1;
  logic [15:0] adr = 16'h0000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [8:0] src = 9'h000;
  logic [31:0] rdat;
  logic ack;
  logic err;
  logic [6:0] outs;
  int fail_count = 0;
  int comparisons = 0;
  logic [31:0] sh2, sh4, got, d2, d4;
  logic gack, gerr;
  logic [3:0] s2, s4;

  // bus clock, 8 ns period
  always #4 clk = ~clk;

  peripheral_clock_source_select dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .supervisor_i(sup), .dat_o(rdat),
    .ack_o(ack), .err_o(err), .loop_locked_clock_i(src[0]), .external_oscillator_clock_i(src[1]),
    .internal_reference_clock_i(src[2]), .low_power_oscillator_i(src[3]),
    .rtc_one_hz_i(src[4]), .ext_clock_input_pin_zero_i(src[5]),
    .ext_clock_input_pin_one_i(src[6]), .timer_one_channel_zero_pin_i(src[7]),
    .analog_comparator_zero_i(src[8]), .serial_port_clock_o(outs[6]),
    .timer_counter_clock_o(outs[5]), .clock_output_pin_o(outs[4]), .rtc_output_pin_o(outs[3]),
    .timer_zero_ext_clock_o(outs[2]), .timer_one_ext_clock_o(outs[1]),
    .timer_one_capture_o(outs[0]));

  // verdict and end of run
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check_word(input logic [31:0] g, input logic [31:0] e, input string m);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic check_flag(input logic g, input logic e, input string m);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, m, g, e);
    end
  endtask

  task automatic check_outs(input logic [6:0] g, input logic [6:0] e, input logic [6:0] k);
    comparisons++;
    if ((g & k) !== (e & k)) begin
      fail_count++;
      $display("MISMATCH t=%0t clock outputs got %b exp %b", $time, g, e);
    end
  endtask

  // one classic wishbone cycle, held until ack or err is sampled
  task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic p);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    sup <= p;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
    gack = ack;
    gerr = err;
    got = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      $display("MISMATCH t=%0t bus cycle never answered", $time);
    end
  endtask

  // byte-lane merge of a write into the shadow copy
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        o[8*b +: 8] = d[8*b +: 8];
      end
    end
    return o;
  endfunction

  function automatic logic pick(input logic [1:0] c, input logic [8:0] v);
    return (c == SRC_OFF) ? 1'b0 : v[c - 2'd1];
  endfunction

  // expected clock outputs from register shadows and source levels
  function automatic logic [6:0] exp_outs(input logic [31:0] r2, input logic [31:0] r4,
                                          input logic [8:0] v);
    logic c;
    case (r2[OUTCLK_SEL_LSB +: 3])
      OUT_LPO: c = v[3];
      OUT_INTREF: c = v[2];
      OUT_EXTOSC: c = v[1];
      default: c = 1'b0;
    endcase
    return {pick(r2[SERIAL_SEL_LSB +: 2], v), pick(r2[COUNTER_SEL_LSB +: 2], v), c,
      r2[RTC_SEL_BIT] ? v[1] : v[4], r4[T0_PIN_SEL_BIT] ? v[6] : v[5],
      r4[T1_PIN_SEL_BIT] ? v[6] : v[5], r4[T1_CAP_SRC_BIT] ? v[8] : v[7]};
  endfunction

  // main sequence
  initial begin
    void'($urandom(58));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int r = 0; r < 2; r++) begin
      sh2 = 32'h0000_0000;
      sh4 = 32'h0000_0000;
      wb(1'b0, OFS_CLOCK_SOURCE_OPTION, 32'h0000_0000, 4'hF, 1'b1);
      check_word(got, RST_CLOCK_SOURCE_OPTION, "clock option reset");
      wb(1'b0, OFS_TIMER_PIN_OPTION, 32'h0000_0000, 4'hF, 1'b1);
      check_word(got, RST_TIMER_PIN_OPTION, "pin option reset");
      wb(1'b0, OFS_OPTION_ONE_CONFIG, 32'h0000_0000, 4'hF, 1'b1);
      check_word(got, RST_OPTION_ONE_CONFIG, "option one reset");
      wb(1'b1, OFS_OPTION_ONE_CONFIG, 32'hFFFF_FFFF, 4'hF, 1'b1);
      wb(1'b0, OFS_OPTION_ONE_CONFIG, 32'h0000_0000, 4'hF, 1'b1);
      check_word(got, 32'h0000_0000, "option one reserved");
      wb(1'b0, 16'h0010, 32'h0000_0000, 4'hF, 1'b1);
      check_flag(gerr, 1'b1, "unmapped err");
      check_outs(outs, exp_outs(sh2, sh4, src), 7'h6F);
      for (int i = 0; i < 24; i++) begin
        src <= 9'h000;
        repeat (8) @(posedge clk);
        d2 = $urandom();
        d4 = $urandom();
        s2 = (i < 8) ? 4'hF : 4'($urandom());
        s4 = (i < 8) ? 4'hF : 4'($urandom());
        if (i < 8) begin
          d2[27:24] = {i[1:0], ~i[1:0]};
          d2[7:5] = i[2:0];
        end
        wb(1'b1, OFS_CLOCK_SOURCE_OPTION, d2, s2, 1'b1);
        check_flag(gack, 1'b1, "write ack");
        sh2 = merge(sh2, d2, s2) & MASK_CLOCK_SOURCE_OPTION;
        wb(1'b1, OFS_TIMER_PIN_OPTION, d4, s4, 1'b1);
        sh4 = merge(sh4, d4, s4) & MASK_TIMER_PIN_OPTION;
        if (i == 12) begin
          wb(1'b1, OFS_CLOCK_SOURCE_OPTION, ~sh2, 4'hF, 1'b0);
          check_flag(gerr, 1'b1, "user write err");
        end
        wb(1'b0, OFS_CLOCK_SOURCE_OPTION, 32'h0000_0000, 4'hF, 1'b1);
        check_word(got, sh2, "clock option read");
        wb(1'b0, OFS_TIMER_PIN_OPTION, 32'h0000_0000, 4'hF, 1'b1);
        check_word(got, sh4, "pin option read");
        src <= 9'($urandom());
        repeat (12) @(posedge clk);
        check_outs(outs, exp_outs(sh2, sh4, src), (sh2[7:5] == OUT_BUS) ? 7'h6F : 7'h7F);
      end
      // second reset in mid-run
      src <= 9'h000;
      repeat (8) @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
    end
    report_and_stop();
  end

  // watchdog against a hung bus
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    report_and_stop();
  end
endmodule
`default_nettype wire

// ---- rtl/clksel_pkg.sv ----
// package for the peripheral clock source selector
// assumes a 32-bit classic wishbone register bus and one bus clock
package clksel_pkg;
  // byte offsets of the registers
  localparam logic [15:0] OFS_OPTION_ONE_CONFIG = 16'h0004;
  localparam logic [15:0] OFS_CLOCK_SOURCE_OPTION = 16'h1004;
  localparam logic [15:0] OFS_TIMER_PIN_OPTION = 16'h100C;
  // reset values
  localparam logic [31:0] RST_OPTION_ONE_CONFIG = 32'h0000_0000;
  localparam logic [31:0] RST_CLOCK_SOURCE_OPTION = 32'h0000_0000;
  localparam logic [31:0] RST_TIMER_PIN_OPTION = 32'h0000_0000;
  // writable bit masks, all else reads zero
  localparam logic [31:0] MASK_OPTION_ONE_CONFIG = 32'h0000_0000;
  localparam logic [31:0] MASK_CLOCK_SOURCE_OPTION = 32'h0F00_00F0;
  localparam logic [31:0] MASK_TIMER_PIN_OPTION = 32'h0304_0000;
  // field positions
  localparam int SERIAL_SEL_LSB = 26;
  localparam int COUNTER_SEL_LSB = 24;
  localparam int OUTCLK_SEL_LSB = 5;
  localparam int RTC_SEL_BIT = 4;
  localparam int T1_PIN_SEL_BIT = 25;
  localparam int T0_PIN_SEL_BIT = 24;
  localparam int T1_CAP_SRC_BIT = 18;
  // source codes
  localparam logic [1:0] SRC_OFF = 2'h0;
  localparam logic [1:0] SRC_LOOP = 2'h1;
  localparam logic [1:0] SRC_EXTOSC = 2'h2;
  localparam logic [1:0] SRC_INTREF = 2'h3;
  localparam logic [2:0] OUT_BUS = 3'h2;
  localparam logic [2:0] OUT_LPO = 3'h3;
  localparam logic [2:0] OUT_INTREF = 3'h4;
  localparam logic [2:0] OUT_EXTOSC = 3'h6;
  // number of clock inputs in a mux and sync depth
  localparam int MUX_INPUTS = 4;
  localparam logic [1:0] SYNC_LAST = 2'h1;
endpackage

// ---- rtl/glitchfree_mux.sv ----
// glitch-free clock multiplexer, one of four sources or off
// assumes source clocks sampled on clk_i well above their rate
`timescale 1ns/1ns
`default_nettype none
module glitchfree_mux
  import clksel_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  glitchfree_mux_if.mux m
);
  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [1:0] cur;
    logic on;
    logic out;
  } mux_state_t;
  mux_state_t q, next_q;
  // resample sources, switch only while the output sits low
  always_comb begin
    next_q = q;
    next_q.s1 = m.clk_in;
    next_q.s2 = q.s1;
    if (!q.out && ((m.sel != q.cur) || (m.en != q.on))) begin
      next_q.cur = m.sel;
      next_q.on = m.en;
      next_q.out = 1'b0;
    end else begin
      next_q.out = q.on & q.s2[q.cur];
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) q <= '0;
    else q <= next_q;
  end
  assign m.clk_out = q.out;
  assign m.active = q.cur;
  // no switch while output high
  a_no_runt_switch: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(q.out) && !$past(rst_i) |-> q.cur == $past(q.cur))
    else $error("mux selection changed while output high");
endmodule
`default_nettype wire

// ---- rtl/glitchfree_mux_if.sv ----
// carrier between the selector top and one glitch-free mux
// assumes both ends share clk_i and rst_i
`timescale 1ns/1ns
`default_nettype none
interface glitchfree_mux_if;
  logic [1:0] sel;
  logic en;
  logic [3:0] clk_in;
  logic clk_out;
  logic [1:0] active;
  modport ctrl (output sel, output en, output clk_in, input clk_out, input active);
  modport mux (input sel, input en, input clk_in, output clk_out, output active);
endinterface
`default_nettype wire

// ---- rtl/peripheral_clock_source_select.sv ----
// peripheral clock source selection registers and clock muxes
// assumes classic wishbone, 32-bit data, clk_i bus clock, rst_i system reset
// How it works
// - serial port clock: off, loop-locked, external oscillator, internal reference
// - timer counter clock: off, loop-locked, external oscillator, internal reference
// - output pin clock: bus, low-power, internal ref, external osc; others reserved
// - rtc output pin: one-hertz clock or external oscillator clock
// - timer one external clock from pin zero or pin one
// - timer zero external clock from pin zero or pin one
// - timer one channel zero capture from its pin or comparator zero
// - reserved bits read zero, writes to them ignored
// - option-one register reset by system reset only
// - writes only in supervisor mode; user writes get bus error
// - clock-source option resets to zero, both clocks off
//
// Our own choice: the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module peripheral_clock_source_select
  import clksel_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [15:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic supervisor_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  input wire logic loop_locked_clock_i,
  input wire logic external_oscillator_clock_i,
  input wire logic internal_reference_clock_i,
  input wire logic low_power_oscillator_i,
  input wire logic rtc_one_hz_i,
  input wire logic ext_clock_input_pin_zero_i,
  input wire logic ext_clock_input_pin_one_i,
  input wire logic timer_one_channel_zero_pin_i,
  input wire logic analog_comparator_zero_i,
  output logic serial_port_clock_o,
  output logic timer_counter_clock_o,
  output logic clock_output_pin_o,
  output logic rtc_output_pin_o,
  output logic timer_zero_ext_clock_o,
  output logic timer_one_ext_clock_o,
  output logic timer_one_capture_o
);
  typedef struct packed {
    logic [31:0] cfg1;
    logic [31:0] csrc;
    logic [31:0] tpin;
    logic [31:0] rdat;
    logic ack;
    logic err;
    logic [3:0] rtc_s1;
    logic [3:0] rtc_s2;
    logic [3:0] cap_s1;
    logic [3:0] cap_s2;
    logic rtc_out;
    logic t0_out;
    logic t1_out;
    logic cap_out;
  } sel_state_t;
  sel_state_t q, next_q;

  glitchfree_mux_if uart_m ();
  glitchfree_mux_if cnt_m ();
  glitchfree_mux_if out_m ();

  logic req;
  logic hit;
  logic [31:0] wmask;
  logic [2:0] osel;
  logic out_valid;
  logic [1:0] out_code;
  logic bus_clk_div;

  assign req = cyc_i & stb_i & ~q.ack & ~q.err;
  assign hit = (adr_i == OFS_OPTION_ONE_CONFIG) || (adr_i == OFS_CLOCK_SOURCE_OPTION) ||
               (adr_i == OFS_TIMER_PIN_OPTION);
  assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign osel = q.csrc[OUTCLK_SEL_LSB +: 3];

  // output pin code map, reserved codes leave the pin low
  always_comb begin
    out_valid = 1'b1;
    out_code = 2'h0;
    case (osel)
      OUT_BUS: out_code = 2'h0;
      OUT_LPO: out_code = 2'h1;
      OUT_INTREF: out_code = 2'h2;
      OUT_EXTOSC: out_code = 2'h3;
      default: out_valid = 1'b0;
    endcase
  end

  // bus clock seen at the pin as quarter rate of clk_i
  assign bus_clk_div = q.rtc_s2[3];

  // mux connections, ordered by select code
  assign uart_m.sel = q.csrc[SERIAL_SEL_LSB +: 2];
  assign uart_m.en = (q.csrc[SERIAL_SEL_LSB +: 2] != SRC_OFF);
  assign uart_m.clk_in = {internal_reference_clock_i, external_oscillator_clock_i,
                          loop_locked_clock_i, 1'b0};
  assign cnt_m.sel = q.csrc[COUNTER_SEL_LSB +: 2];
  assign cnt_m.en = (q.csrc[COUNTER_SEL_LSB +: 2] != SRC_OFF);
  assign cnt_m.clk_in = uart_m.clk_in;
  assign out_m.sel = out_code;
  assign out_m.en = out_valid;
  assign out_m.clk_in = {external_oscillator_clock_i, internal_reference_clock_i,
                         low_power_oscillator_i, bus_clk_div};

  glitchfree_mux u_uart (.clk_i(clk_i), .rst_i(rst_i), .m(uart_m.mux));
  glitchfree_mux u_cnt (.clk_i(clk_i), .rst_i(rst_i), .m(cnt_m.mux));
  glitchfree_mux u_out (.clk_i(clk_i), .rst_i(rst_i), .m(out_m.mux));

  // register bus, single-cycle answer, then ack drops
  always_comb begin
    next_q = q;
    next_q.ack = 1'b0;
    next_q.err = 1'b0;
    // pin inputs pass two flops: bus clock divider bit, rtc, pin0, pin1
    next_q.rtc_s1 = {~q.rtc_s2[3], rtc_one_hz_i, ext_clock_input_pin_zero_i,
                     ext_clock_input_pin_one_i};
    next_q.rtc_s2 = q.rtc_s1;
    // capture flops also carry the oscillator for the rtc pin
    next_q.cap_s1 = {1'b0, external_oscillator_clock_i, timer_one_channel_zero_pin_i,
                     analog_comparator_zero_i};
    next_q.cap_s2 = q.cap_s1;
    if (req) begin
      if (we_i && !supervisor_i) begin
        next_q.err = 1'b1;
      end else begin
        next_q.ack = 1'b1;
        if (we_i) begin
          case (adr_i)
            OFS_OPTION_ONE_CONFIG: next_q.cfg1 = (q.cfg1 & ~(wmask & MASK_OPTION_ONE_CONFIG)) |
              (dat_i & wmask & MASK_OPTION_ONE_CONFIG);
            OFS_CLOCK_SOURCE_OPTION: next_q.csrc = (q.csrc &
              ~(wmask & MASK_CLOCK_SOURCE_OPTION)) | (dat_i & wmask & MASK_CLOCK_SOURCE_OPTION);
            OFS_TIMER_PIN_OPTION: next_q.tpin = (q.tpin & ~(wmask & MASK_TIMER_PIN_OPTION)) |
              (dat_i & wmask & MASK_TIMER_PIN_OPTION);
            default: next_q.tpin = q.tpin;
          endcase
          next_q.rdat = 32'h0000_0000;
        end else begin
          case (adr_i)
            OFS_OPTION_ONE_CONFIG: next_q.rdat = q.cfg1 & MASK_OPTION_ONE_CONFIG;
            OFS_CLOCK_SOURCE_OPTION: next_q.rdat = q.csrc & MASK_CLOCK_SOURCE_OPTION;
            OFS_TIMER_PIN_OPTION: next_q.rdat = q.tpin & MASK_TIMER_PIN_OPTION;
            default: next_q.rdat = 32'h0000_0000;
          endcase
        end
        if (!hit) begin
          next_q.ack = 1'b0;
          next_q.err = 1'b1;
        end
      end
    end
    // rtc pin: synchronised oscillator or 1 Hz clock
    next_q.rtc_out = q.csrc[RTC_SEL_BIT] ? q.cap_s2[2] : q.rtc_s2[2];
    next_q.t0_out = q.tpin[T0_PIN_SEL_BIT] ? q.rtc_s2[0] : q.rtc_s2[1];
    next_q.t1_out = q.tpin[T1_PIN_SEL_BIT] ? q.rtc_s2[0] : q.rtc_s2[1];
    next_q.cap_out = q.tpin[T1_CAP_SRC_BIT] ? q.cap_s2[0] : q.cap_s2[1];
  end

  // system reset clears all option registers, no low-leakage path here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.cfg1 <= RST_OPTION_ONE_CONFIG;
      q.csrc <= RST_CLOCK_SOURCE_OPTION;
      q.tpin <= RST_TIMER_PIN_OPTION;
    end else begin
      q <= next_q;
    end
  end

  assign dat_o = q.rdat;
  assign ack_o = q.ack;
  assign err_o = q.err;
  assign serial_port_clock_o = uart_m.clk_out;
  assign timer_counter_clock_o = cnt_m.clk_out;
  assign clock_output_pin_o = out_m.clk_out;
  assign rtc_output_pin_o = q.rtc_out;
  assign timer_zero_ext_clock_o = q.t0_out;
  assign timer_one_ext_clock_o = q.t1_out;
  assign timer_one_capture_o = q.cap_out;

  a_user_write_err: assert property (@(posedge clk_i) disable iff (rst_i)
    req && we_i && !supervisor_i |=> err_o && !ack_o) else $error("user write not refused");
  a_user_write_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    req && we_i && !supervisor_i |=> $stable(q.csrc) && $stable(q.tpin))
    else $error("user write changed state");
  a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    ((q.csrc & ~MASK_CLOCK_SOURCE_OPTION) == 32'h0000_0000) &&
    ((q.tpin & ~MASK_TIMER_PIN_OPTION) == 32'h0000_0000) && (q.cfg1 == 32'h0000_0000))
    else $error("reserved bit set");
  a_serial_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (q.csrc[27:26] == SRC_OFF) [*4] |-> !serial_port_clock_o)
    else $error("serial clock runs while off");
  a_counter_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (q.csrc[25:24] == SRC_OFF) [*4] |-> !timer_counter_clock_o)
    else $error("counter clock runs while off");
  a_outpin_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
    !out_valid [*4] |-> !clock_output_pin_o) else $error("reserved code drives pin");
  a_t0_pin_route: assert property (@(posedge clk_i) disable iff (rst_i)
    $stable(q.tpin) |=> timer_zero_ext_clock_o ==
    ($past(q.tpin[T0_PIN_SEL_BIT]) ? $past(q.rtc_s2[0]) : $past(q.rtc_s2[1])))
    else $error("timer zero pin route wrong");
  a_t1_pin_route: assert property (@(posedge clk_i) disable iff (rst_i)
    $stable(q.tpin) |=> timer_one_ext_clock_o ==
    ($past(q.tpin[T1_PIN_SEL_BIT]) ? $past(q.rtc_s2[0]) : $past(q.rtc_s2[1])))
    else $error("timer one pin route wrong");
  a_capture_route: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> timer_one_capture_o ==
    ($past(q.tpin[T1_CAP_SRC_BIT]) ? $past(q.cap_s2[0]) : $past(q.cap_s2[1])))
    else $error("capture route wrong");
  a_rtc_route: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> rtc_output_pin_o ==
    ($past(q.csrc[RTC_SEL_BIT]) ? $past(q.cap_s2[2]) : $past(q.rtc_s2[2])))
    else $error("rtc route wrong");
  a_reset_zero: assert property (@(posedge clk_i)
    $past(rst_i) |-> q.csrc == RST_CLOCK_SOURCE_OPTION && q.cfg1 == RST_OPTION_ONE_CONFIG)
    else $error("reset value wrong");
  c_sup_write: cover property (@(posedge clk_i) req && we_i && supervisor_i && hit);
  c_user_write: cover property (@(posedge clk_i) req && we_i && !supervisor_i);
  c_serial_on: cover property (@(posedge clk_i) serial_port_clock_o);
  c_outpin_on: cover property (@(posedge clk_i) clock_output_pin_o);
endmodule
`default_nettype wire
